// File: rtl/fcl_map.vh
// fuse bank offsets, field positions, default values and start-up timing
// assumes inclusion by the loader only; definitions only
`ifndef FCL_MAP_VH
`define FCL_MAP_VH
`define FCL_OFF_WATCHDOG 4'h0
`define FCL_OFF_BROWNOUT 4'h1
`define FCL_OFF_OSCILLATOR 4'h2
`define FCL_OFF_SYSTEM_A 4'h5
`define FCL_OFF_SYSTEM_B 4'h6
`define FCL_OFF_CODE_BLOCKS 4'h7
`define FCL_OFF_BOOT_BLOCKS 4'h8
`define FCL_OFF_LAST 4'h8
`define FCL_DEF_WATCHDOG 8'h00
`define FCL_DEF_BROWNOUT 8'h00
`define FCL_DEF_OSCILLATOR 8'h00
`define FCL_DEF_SYSTEM_A 8'hC0
`define FCL_DEF_SYSTEM_B 8'h08
`define FCL_DEF_CODE_BLOCKS 8'h00
`define FCL_DEF_BOOT_BLOCKS 8'h00
`define FCL_WD_WINDOW_HI 7
`define FCL_WD_WINDOW_LO 4
`define FCL_WD_PERIOD_HI 3
`define FCL_WD_PERIOD_LO 0
`define FCL_BO_THRESH_HI 7
`define FCL_BO_THRESH_LO 5
`define FCL_BO_RATE_BIT 4
`define FCL_BO_ACTIVE_HI 3
`define FCL_BO_ACTIVE_LO 2
`define FCL_BO_SLEEP_HI 1
`define FCL_BO_SLEEP_LO 0
`define FCL_BO_THRESH_MAX 3'h3
`define FCL_MODE_RESERVED 2'h3
`define FCL_OSC_HI 3
`define FCL_OSC_LO 0
`define FCL_OSC_FAST 4'h0
`define FCL_OSC_SLOW 4'h1
`define FCL_SA_CRC_SOURCE_FIELD_HI 7
`define FCL_SA_CRC_SOURCE_FIELD_LO 6
`define FCL_SA_CRCTYPE_BIT 5
`define FCL_SA_RSTPIN_BIT 3
`define FCL_SA_RETAIN_BIT 0
`define FCL_SB_SUPPLY_HI 4
`define FCL_SB_SUPPLY_LO 3
`define FCL_SB_DELAY_HI 2
`define FCL_SB_DELAY_LO 0
`define FCL_SUPPLY_DUAL 2'h1
`define FCL_SUPPLY_SINGLE 2'h2
`define FCL_CRC_NONE 2'h3
`define FCL_CLK_MHZ 20
`define FCL_DELAY_UNIT_MS 1
`define FCL_DELAY_UNIT_CYCLES (`FCL_DELAY_UNIT_MS * `FCL_CLK_MHZ * 1000)
`endif

// File: rtl/fcl_fuse_loader.v
// fuse configuration loader: reads the fuse bank after reset, waits the
// start-up delay, then copies each field into its target control outputs.
// assumes a synchronous fuse read port (data one cycle after address) on clk_in.
// limitation: an erase seen before the system a read lands uses the default retention bit
// Functional notes
// (RQ1) watchdog fuse bits 7:4 go to the watchdog window field after start-up
// (RQ2) watchdog fuse bits 3:0 go to the watchdog period field after start-up
// (RQ3) brown-out bits 7:5 load the threshold; codes above 3 are reserved
// (RQ4) brown-out bit 4 loads sampling rate: 0 is 128 Hz, 1 is 32 Hz
// (RQ5) active mode: 0 off, 1 continuous, 2 sampled, 3 continuous with wake hold
// (RQ6) sleep mode bits 1:0 load the detector; code 3 is reserved
// (RQ7) oscillator field: 0 fast internal, 1 slow internal, others reserved
// (RQ8) crc source: 0 full flash, 1 boot, 2 boot plus code, 3 skip
// (RQ9) crc type bit: clear gives 16-bit CCITT, set gives 32-bit Ethernet
// (RQ10) reset pin bit: clear plain input, set external reset with pull-up
// (RQ11) chip erase erases eeprom unless retention bit is one
// (RQ12) when locked, chip erase always erases eeprom
// (RQ13) supply mode: 1 dual, 2 single, 0 and 3 reserved
// (RQ14) start-up delay code 0 none, 1 to 7 give 1 to 64 ms
// (RQ15) code size fuse counts boot plus application in 512-byte blocks
// (RQ16) boot size in 512-byte blocks; zero makes all flash boot
// (RQ17) new fuse values take effect only after the next reset
// (RQ18) only the debug port programs fuses; the processor only reads
// (RQ19) fuse programmers write reserved bits as zero
// (RQ20) each fuse is captured once per reset and held until next reset
`timescale 1ns/1ps
`default_nettype none
`include "fcl_map.vh"
module fcl_fuse_loader #(
	parameter DELAY_UNIT_CYCLES = `FCL_DELAY_UNIT_CYCLES,
	parameter FLASH_BLOCKS = 64
) (
	input wire clk_in,
	input wire reset_in,
	output wire [3:0] fuse_addr_out,
	output wire fuse_rd_out,
	input wire [7:0] fuse_data_in,
	input wire chip_erase_in,
	input wire locked_in,
	output reg load_done_out,
	output reg [3:0] wd_window_out,
	output reg [3:0] wd_period_out,
	output reg [2:0] brownout_threshold_out,
	output reg brownout_threshold_reserved_out,
	output reg brownout_sampling_rate_out,
	output reg [1:0] bo_active_mode_out,
	output reg bo_active_wake_hold_out,
	output reg [1:0] bo_sleep_mode_out,
	output reg bo_sleep_reserved_out,
	output reg [3:0] default_clock_source_out,
	output reg clock_source_slow_out,
	output reg clock_source_reserved_out,
	output reg [1:0] crc_source_field_out,
	output reg crc_scan_enable_out,
	output reg crc_type_select_out,
	output reg reset_pin_function_out,
	output reg reset_pin_pullup_out,
	output reg eeprom_erase_out,
	output reg [1:0] supply_mode_field_out,
	output reg supply_reserved_out,
	output reg [2:0] startup_delay_field_out,
	output reg [7:0] code_section_blocks_out,
	output reg [7:0] boot_section_blocks_out,
	output reg boot_whole_flash_out
);
	localparam ST_READ = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_DONE = 3'b100;

	// delay in ms for a start-up code: 0 gives none, n gives 2^(n-1)
	function [6:0] delay_ms;
		input [2:0] code;
		begin
			if (code == 3'h0) begin
				delay_ms = 7'h00;
			end else begin
				delay_ms = 7'h01 << (code - 3'h1);
			end
		end
	endfunction

	// a two-bit mode field holding its top code
	function mode_is_top;
		input [1:0] mode;
		begin
			mode_is_top = (mode == `FCL_MODE_RESERVED);
		end
	endfunction

	// section size, or the whole flash when the boot size is zero
	function [7:0] blocks_or_flash;
		input [7:0] value;
		input [7:0] boot;
		begin
			if (boot == 8'h00) begin
				blocks_or_flash = FLASH_BLOCKS[7:0];
			end else begin
				blocks_or_flash = value;
			end
		end
	endfunction

	reg [2:0] state_r;
	reg [3:0] addr_r;
	reg rd_pend_r;
	reg [3:0] rd_addr_r;

	// fuse copies, defaults until their read lands
	reg [7:0] wd_r;
	reg [7:0] bo_r;
	reg [7:0] osc_r;
	reg [7:0] sa_r;
	reg [7:0] sb_r;
	reg [7:0] cs_r;
	reg [7:0] bs_r;

	// start-up delay counters
	reg [6:0] ms_left_r;
	reg [31:0] unit_cnt_r;

	// two-stage synchronisers for the erase and lock levels
	reg erase_meta_r;
	reg erase_sync_r;
	reg lock_meta_r;
	reg lock_sync_r;

	assign fuse_addr_out = addr_r;
	assign fuse_rd_out = (state_r == ST_READ) && (addr_r <= `FCL_OFF_LAST);

	// capture pass: each fuse is read exactly once after reset (RQ20)
	always @(posedge clk_in) begin
		if (reset_in) begin
			state_r <= ST_READ;
			addr_r <= 4'h0;
			rd_pend_r <= 1'b0;
			rd_addr_r <= 4'h0;
			wd_r <= `FCL_DEF_WATCHDOG;
			bo_r <= `FCL_DEF_BROWNOUT;
			osc_r <= `FCL_DEF_OSCILLATOR;
			sa_r <= `FCL_DEF_SYSTEM_A;
			sb_r <= `FCL_DEF_SYSTEM_B;
			cs_r <= `FCL_DEF_CODE_BLOCKS;
			bs_r <= `FCL_DEF_BOOT_BLOCKS;
			ms_left_r <= 7'h00;
			unit_cnt_r <= 32'h0;
		end else begin
			rd_pend_r <= fuse_rd_out;
			rd_addr_r <= addr_r;
			if (rd_pend_r) begin
				case (rd_addr_r)
					`FCL_OFF_WATCHDOG: wd_r <= fuse_data_in;
					`FCL_OFF_BROWNOUT: bo_r <= fuse_data_in;
					`FCL_OFF_OSCILLATOR: osc_r <= fuse_data_in;
					`FCL_OFF_SYSTEM_A: sa_r <= fuse_data_in;
					`FCL_OFF_SYSTEM_B: sb_r <= fuse_data_in;
					`FCL_OFF_CODE_BLOCKS: cs_r <= fuse_data_in;
					`FCL_OFF_BOOT_BLOCKS: bs_r <= fuse_data_in;
					default: ;
				endcase
			end
			case (state_r)
				ST_READ: begin
					if (addr_r <= `FCL_OFF_LAST) begin
						addr_r <= addr_r + 4'h1;
					end else if (!rd_pend_r) begin
						// delay code valid once the system b read landed; leaving waits for the last read
						ms_left_r <= delay_ms(sb_r[`FCL_SB_DELAY_HI:`FCL_SB_DELAY_LO]); // RQ14
						unit_cnt_r <= 32'h0;
						state_r <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					// code 0 still spends one cycle here before loading
					if (ms_left_r == 7'h00) begin
						state_r <= ST_DONE;
					end else if (unit_cnt_r == DELAY_UNIT_CYCLES - 1) begin
						unit_cnt_r <= 32'h0;
						ms_left_r <= ms_left_r - 7'h01;
					end else begin
						unit_cnt_r <= unit_cnt_r + 32'h1;
					end
				end
				ST_DONE: begin
					state_r <= ST_DONE;
				end
				default: begin
					state_r <= ST_READ;
				end
			endcase
		end
	end

	// erase request and lock state come from other logic domains
	always @(posedge clk_in) begin
		if (reset_in) begin
			erase_meta_r <= 1'b0;
			erase_sync_r <= 1'b0;
			lock_meta_r <= 1'b0;
			lock_sync_r <= 1'b0;
		end else begin
			erase_meta_r <= chip_erase_in;
			erase_sync_r <= erase_meta_r;
			lock_meta_r <= locked_in;
			lock_sync_r <= lock_meta_r;
		end
	end

	// decoded targets from the fuse copies; the load edge registers all but erase_nxt, which is registered every cycle
	reg [3:0] wd_window_nxt;
	reg [3:0] wd_period_nxt;
	reg [2:0] bo_thresh_nxt;
	reg bo_thresh_res_nxt;
	reg bo_rate_nxt;
	reg [1:0] bo_active_nxt;
	reg bo_wake_nxt;
	reg [1:0] bo_sleep_nxt;
	reg bo_sleep_res_nxt;
	reg [3:0] clk_src_nxt;
	reg clk_slow_nxt;
	reg clk_res_nxt;
	reg [1:0] crc_src_nxt;
	reg crc_en_nxt;
	reg crc_type_nxt;
	reg pin_fn_nxt;
	reg pin_pull_nxt;
	reg [1:0] supply_nxt;
	reg supply_res_nxt;
	reg [2:0] delay_field_nxt;
	reg [7:0] code_blocks_nxt;
	reg [7:0] boot_blocks_nxt;
	reg boot_whole_nxt;
	reg erase_nxt;

	always @* begin
		// watchdog
		wd_window_nxt = wd_r[`FCL_WD_WINDOW_HI:`FCL_WD_WINDOW_LO]; // RQ1
		wd_period_nxt = wd_r[`FCL_WD_PERIOD_HI:`FCL_WD_PERIOD_LO]; // RQ2

		// brown-out detector
		bo_thresh_nxt = bo_r[`FCL_BO_THRESH_HI:`FCL_BO_THRESH_LO]; // RQ3
		bo_thresh_res_nxt = bo_r[`FCL_BO_THRESH_HI:`FCL_BO_THRESH_LO] > `FCL_BO_THRESH_MAX; // RQ3
		bo_rate_nxt = bo_r[`FCL_BO_RATE_BIT]; // RQ4
		bo_active_nxt = bo_r[`FCL_BO_ACTIVE_HI:`FCL_BO_ACTIVE_LO]; // RQ5
		bo_wake_nxt = mode_is_top(bo_r[`FCL_BO_ACTIVE_HI:`FCL_BO_ACTIVE_LO]); // RQ5
		bo_sleep_nxt = bo_r[`FCL_BO_SLEEP_HI:`FCL_BO_SLEEP_LO]; // RQ6
		bo_sleep_res_nxt = mode_is_top(bo_r[`FCL_BO_SLEEP_HI:`FCL_BO_SLEEP_LO]); // RQ6

		// oscillator
		clk_src_nxt = osc_r[`FCL_OSC_HI:`FCL_OSC_LO]; // RQ7
		clk_slow_nxt = osc_r[`FCL_OSC_HI:`FCL_OSC_LO] == `FCL_OSC_SLOW; // RQ7
		clk_res_nxt = osc_r[`FCL_OSC_HI:`FCL_OSC_LO] != `FCL_OSC_FAST &&
			osc_r[`FCL_OSC_HI:`FCL_OSC_LO] != `FCL_OSC_SLOW; // RQ7

		// system fuse a
		crc_src_nxt = sa_r[`FCL_SA_CRC_SOURCE_FIELD_HI:`FCL_SA_CRC_SOURCE_FIELD_LO]; // RQ8
		crc_en_nxt = !mode_is_top(sa_r[`FCL_SA_CRC_SOURCE_FIELD_HI:`FCL_SA_CRC_SOURCE_FIELD_LO]); // RQ8
		crc_type_nxt = sa_r[`FCL_SA_CRCTYPE_BIT]; // RQ9
		pin_fn_nxt = sa_r[`FCL_SA_RSTPIN_BIT]; // RQ10
		pin_pull_nxt = sa_r[`FCL_SA_RSTPIN_BIT]; // RQ10

		// system fuse b
		supply_nxt = sb_r[`FCL_SB_SUPPLY_HI:`FCL_SB_SUPPLY_LO]; // RQ13
		supply_res_nxt = sb_r[`FCL_SB_SUPPLY_HI:`FCL_SB_SUPPLY_LO] != `FCL_SUPPLY_DUAL &&
			sb_r[`FCL_SB_SUPPLY_HI:`FCL_SB_SUPPLY_LO] != `FCL_SUPPLY_SINGLE; // RQ13
		delay_field_nxt = sb_r[`FCL_SB_DELAY_HI:`FCL_SB_DELAY_LO]; // RQ14

		// zero boot size makes every block boot; code size then unused
		boot_whole_nxt = (bs_r == 8'h00); // RQ16
		boot_blocks_nxt = blocks_or_flash(bs_r, bs_r); // RQ16
		code_blocks_nxt = blocks_or_flash(cs_r, bs_r); // RQ15

		// lock overrides the retention bit
		erase_nxt = erase_sync_r && (lock_sync_r || !sa_r[`FCL_SA_RETAIN_BIT]); // RQ11 RQ12
	end

	// targets load once at end of start-up, then freeze until reset (RQ17)
	always @(posedge clk_in) begin
		if (reset_in) begin
			load_done_out <= 1'b0;
			wd_window_out <= 4'h0;
			wd_period_out <= 4'h0;
			brownout_threshold_out <= 3'h0;
			brownout_threshold_reserved_out <= 1'b0;
			brownout_sampling_rate_out <= 1'b0;
			bo_active_mode_out <= 2'h0;
			bo_active_wake_hold_out <= 1'b0;
			bo_sleep_mode_out <= 2'h0;
			bo_sleep_reserved_out <= 1'b0;
			default_clock_source_out <= 4'h0;
			clock_source_slow_out <= 1'b0;
			clock_source_reserved_out <= 1'b0;
			crc_source_field_out <= 2'h0;
			crc_scan_enable_out <= 1'b0;
			crc_type_select_out <= 1'b0;
			reset_pin_function_out <= 1'b0;
			reset_pin_pullup_out <= 1'b0;
			supply_mode_field_out <= 2'h0;
			supply_reserved_out <= 1'b0;
			startup_delay_field_out <= 3'h0;
			code_section_blocks_out <= 8'h00;
			boot_section_blocks_out <= 8'h00;
			boot_whole_flash_out <= 1'b0;
		end else if (state_r == ST_DONE && !load_done_out) begin
			load_done_out <= 1'b1; // RQ20
			wd_window_out <= wd_window_nxt; // RQ1
			wd_period_out <= wd_period_nxt; // RQ2
			brownout_threshold_out <= bo_thresh_nxt; // RQ3
			brownout_threshold_reserved_out <= bo_thresh_res_nxt; // RQ3
			brownout_sampling_rate_out <= bo_rate_nxt; // RQ4
			bo_active_mode_out <= bo_active_nxt; // RQ5
			bo_active_wake_hold_out <= bo_wake_nxt; // RQ5
			bo_sleep_mode_out <= bo_sleep_nxt; // RQ6
			bo_sleep_reserved_out <= bo_sleep_res_nxt; // RQ6
			default_clock_source_out <= clk_src_nxt; // RQ7
			clock_source_slow_out <= clk_slow_nxt; // RQ7
			clock_source_reserved_out <= clk_res_nxt; // RQ7
			crc_source_field_out <= crc_src_nxt; // RQ8
			crc_scan_enable_out <= crc_en_nxt; // RQ8
			crc_type_select_out <= crc_type_nxt; // RQ9
			reset_pin_function_out <= pin_fn_nxt; // RQ10
			reset_pin_pullup_out <= pin_pull_nxt; // RQ10
			supply_mode_field_out <= supply_nxt; // RQ13
			supply_reserved_out <= supply_res_nxt; // RQ13
			startup_delay_field_out <= delay_field_nxt; // RQ14
			boot_whole_flash_out <= boot_whole_nxt; // RQ16
			boot_section_blocks_out <= boot_blocks_nxt; // RQ16
			code_section_blocks_out <= code_blocks_nxt; // RQ15
		end
	end

	// erase decision uses the retention bit in sa_r, the default until the system a read lands; lock overrides
	always @(posedge clk_in) begin
		if (reset_in) begin
			eeprom_erase_out <= 1'b0;
		end else begin
			eeprom_erase_out <= erase_nxt; // RQ11 RQ12
		end
	end
endmodule
`default_nettype wire

// File: bench/fcl_fuse_store.sv
// fuse bank model with a read port for the loader and a debug write port
// assumes one read per cycle; data is valid the cycle after the address
`timescale 1ns/1ps
`default_nettype none
module fcl_fuse_store (
	input wire logic clk_in,
	input wire logic [3:0] addr_in,
	input wire logic rd_in,
	output logic [7:0] data_out,
	input wire logic pgm_we_in,
	input wire logic [3:0] pgm_addr_in,
	input wire logic [7:0] pgm_data_in
);
	logic [7:0] mem [16] = '{default: 8'h00};
	initial data_out = 8'h00;
	always @(posedge clk_in) begin
		if (pgm_we_in)
			mem[pgm_addr_in] <= pgm_data_in;
		// a released bus inverts its last byte every cycle, so stale captures show up
		if (rd_in)
			data_out <= mem[addr_in];
		else
			data_out <= ~data_out;
	end
endmodule
`default_nettype wire

// File: bench/fcl_fuse_loader_assertions.sv
// checker on the loader's ports
// assumes one clock and the synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module fcl_fuse_loader_checker (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic chip_erase_in,
	input wire logic locked_in,
	input wire logic load_done_out,
	input wire logic [3:0] wd_window_out,
	input wire logic [3:0] wd_period_out,
	input wire logic [1:0] bo_active_mode_out,
	input wire logic bo_active_wake_hold_out,
	input wire logic [1:0] bo_sleep_mode_out,
	input wire logic bo_sleep_reserved_out,
	input wire logic [1:0] crc_source_field_out,
	input wire logic crc_scan_enable_out,
	input wire logic reset_pin_function_out,
	input wire logic reset_pin_pullup_out,
	input wire logic eeprom_erase_out,
	input wire logic [1:0] supply_mode_field_out,
	input wire logic supply_reserved_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	property p_done_hold; load_done_out |=> load_done_out; endproperty
	a_done_hold: assert property (p_done_hold) else $error("load done dropped");
	property p_cfg_hold;
		load_done_out |=> $stable({wd_window_out, wd_period_out, crc_source_field_out});
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("loaded field changed");
	property p_wake; load_done_out |-> bo_active_wake_hold_out == (bo_active_mode_out == 2'h3); endproperty
	a_wake: assert property (p_wake) else $error("wake hold flag wrong");
	property p_sleep; load_done_out |-> bo_sleep_reserved_out == (bo_sleep_mode_out == 2'h3); endproperty
	a_sleep: assert property (p_sleep) else $error("sleep reserved flag wrong");
	property p_crc; load_done_out |-> crc_scan_enable_out == (crc_source_field_out != 2'h3); endproperty
	a_crc: assert property (p_crc) else $error("scan enable wrong");
	property p_pull; reset_pin_pullup_out == reset_pin_function_out; endproperty
	a_pull: assert property (p_pull) else $error("pull-up differs from pin function");
	property p_supply;
		load_done_out |-> supply_reserved_out == !(supply_mode_field_out inside {2'h1, 2'h2});
	endproperty
	a_supply: assert property (p_supply) else $error("supply reserved flag wrong");
	property p_erase; (chip_erase_in && locked_in) [*4] |-> eeprom_erase_out; endproperty
	a_erase: assert property (p_erase) else $error("locked erase kept eeprom");
endmodule
bind fcl_fuse_loader fcl_fuse_loader_checker chk_i (.*);
`default_nettype wire

// File: bench/fcl_fuse_loader_test.sv
// self-checking bench for the fuse loader
// assumes the fuse store model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module fcl_fuse_loader_test;
	localparam int DU = 4;
	localparam int FB = 64;
	logic clk_in = 0, reset_in = 1, chip_erase_in = 0, locked_in = 0, pgm_we = 0;
	logic [3:0] pgm_addr = 4'h0;
	logic [7:0] pgm_data = 8'h00;
	wire [7:0] fuse_data_in, code_section_blocks_out, boot_section_blocks_out;
	wire [3:0] fuse_addr_out, wd_window_out, wd_period_out, default_clock_source_out;
	wire [2:0] brownout_threshold_out, startup_delay_field_out;
	wire [1:0] bo_active_mode_out, bo_sleep_mode_out, crc_source_field_out, supply_mode_field_out;
	wire fuse_rd_out, load_done_out, brownout_threshold_reserved_out, brownout_sampling_rate_out;
	wire bo_active_wake_hold_out, bo_sleep_reserved_out, clock_source_slow_out, eeprom_erase_out;
	wire clock_source_reserved_out, crc_scan_enable_out, crc_type_select_out, supply_reserved_out;
	wire reset_pin_function_out, reset_pin_pullup_out, boot_whole_flash_out;
	int err_count = 0, n_checks = 0, base = 0, cnt = 0;
	// bytes: watchdog, brown-out, oscillator, system a, system b, code, boot; reserved bits zero
	logic [55:0] rows [4] = '{56'h5A000000081004, 56'hC3350169112000,
		56'h0F4A058802FF01, 56'hF0EF0FC11B00FF};
	always #25 clk_in = ~clk_in;
	fcl_fuse_loader #(.DELAY_UNIT_CYCLES(DU), .FLASH_BLOCKS(FB)) dut (.*);
	fcl_fuse_store store (.clk_in(clk_in), .addr_in(fuse_addr_out), .rd_in(fuse_rd_out),
		.data_out(fuse_data_in), .pgm_we_in(pgm_we), .pgm_addr_in(pgm_addr), .pgm_data_in(pgm_data));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic prog(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		pgm_we <= 1'b1;
		pgm_addr <= a;
		pgm_data <= d;
		@(posedge clk_in);
		pgm_we <= 1'b0;
	endtask
	task automatic load(input logic [55:0] f, output int n);
		reset_in <= 1'b1;
		prog(4'h0, f[55:48]);
		prog(4'h1, f[47:40]);
		prog(4'h2, f[39:32]);
		prog(4'h5, f[31:24]);
		prog(4'h6, f[23:16]);
		prog(4'h7, f[15:8]);
		prog(4'h8, f[7:0]);
		@(posedge clk_in);
		reset_in <= 1'b0;
		n = 0;
		while (load_done_out !== 1'b1 && n < 400) begin
			@(negedge clk_in);
			n++;
		end
		if (n >= 400)
			chk("load_done", 1, load_done_out);
	endtask
	task automatic check_row(input logic [55:0] f);
		logic [7:0] w, b, o, a, s, c, z;
		{w, b, o, a, s, c, z} = f;
		chk("wd", w, {wd_window_out, wd_period_out});
		chk("bo", b, {brownout_threshold_out, brownout_sampling_rate_out, bo_active_mode_out,
			bo_sleep_mode_out});
		chk("bo_dec", {b[7:5] > 3, b[3:2] == 3, b[1:0] == 3}, {brownout_threshold_reserved_out,
			bo_active_wake_hold_out, bo_sleep_reserved_out});
		chk("osc", {o[3:0], o[3:0] == 1, o[3:0] > 1}, {default_clock_source_out,
			clock_source_slow_out, clock_source_reserved_out});
		chk("sys_a", {a[7:5], a[7:6] != 3, a[3], a[3]}, {crc_source_field_out, crc_type_select_out,
			crc_scan_enable_out, reset_pin_function_out, reset_pin_pullup_out});
		chk("sys_b", {s[4:0], s[4:3] != 1 && s[4:3] != 2}, {supply_mode_field_out,
			startup_delay_field_out, supply_reserved_out});
		chk("size", {z == 0 ? 8'(FB) : c, z == 0 ? 8'(FB) : z, z == 0}, {code_section_blocks_out,
			boot_section_blocks_out, boot_whole_flash_out});
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk_in);
		for (int i = 0; i < 4; i++) begin
			load(rows[i], cnt);
			if (i == 0)
				base = cnt;
			check_row(rows[i]);
			chk("delay", rows[i][18:16] == 0 ? 0 : DU << (rows[i][18:16] - 1), cnt - base);
			@(posedge clk_in);
			chip_erase_in <= 1'b1;
			repeat (5) @(negedge clk_in);
			chk("erase", !rows[i][24], eeprom_erase_out);
			@(posedge clk_in);
			locked_in <= 1'b1;
			repeat (5) @(negedge clk_in);
			chk("erase_locked", 1, eeprom_erase_out);
			@(posedge clk_in);
			chip_erase_in <= 1'b0;
			locked_in <= 1'b0;
			$display("row %0d done", i);
		end
		load(56'h12000000070000, cnt);
		chk("delay_max", DU << 6, cnt - base);
		prog(4'h0, 8'h34);
		repeat (3) @(negedge clk_in);
		chk("hold", 8'h12, {wd_window_out, wd_period_out});
		load(56'h34000000080000, cnt);
		check_row(56'h34000000080000);
		$display("reprogram test done");
		end_of_test;
	end
	initial begin
		repeat (4000) @(posedge clk_in);
		err_count++;
		end_of_test;
	end
endmodule
`default_nettype wire
